// file: verilog/acc_conversion_control.sv
// Converter control register, clock divider and conversion sequencer.
`timescale 1ns/1ns
// Behaviour
// R1: Clock field codes 001..101 divide by 2..32.
// R2: Clock code 000 passes base clock undivided.
// R3: Acquisition field selects 2, 4, 8, 16 clocks.
// R4: Start enable gates starts, not running continuous.
// R5: Busy enable gates the busy output pin.
// R6: Power bit selects normal or power-down; 5us settle.
// R7: Mode 00 single-ended, 01 differential, 11 reserved.
// R8: Mode 10 selects pseudo differential input.
// R9: Type 000 pin, 001 timer one, 010 timer zero.
// R10: Type 011 single software, then rewrites 000.
// R11: Type 100 converts back to back continuously.
// R12: Type 101 triggers from the logic array.
// R13: Software clears start enable after single launch.
// R14: Busy held from acquisition start until result.
module acc_conversion_control (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst,
  // AXI4-Lite write address and data channels.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Trigger sources, sampled as levels on converter ticks while idle.
  input wire logic i_conversion_start_pin,
  input wire logic i_general_timer_one,
  input wire logic i_general_timer_zero,
  input wire logic i_logic_array_trigger,
  // Analog core interface.
  output logic o_converter_power,
  output logic [1:0] o_conv_mode,
  output logic o_converter_base_tick,
  output logic o_sample,
  output logic o_result_strobe,
  // External busy pin.
  output logic o_converter_busy_pin
);
  // Control register and its fields.
  logic [15:0] ctrl_reg;
  logic [2:0] clk_code;
  logic [1:0] acq_code;
  logic [2:0] type_code;
  // Write channel latches for either-order acceptance.
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  // Divider and sequencer state.
  logic [4:0] div_cnt_reg;
  logic [4:0] div_limit;
  logic conv_tick;
  acc_pkg::acc_state_t state_reg;
  logic [4:0] phase_cnt_reg;
  logic [4:0] acq_limit;
  logic trigger;
  logic single_done;
  // Power-up settle counter; status shows when settled.
  logic [15:0] pwr_cnt_reg;
  logic pwr_ready;

  assign clk_code = ctrl_reg[acc_pkg::CLK_SPEED_LSB +: 3];
  assign acq_code = ctrl_reg[acc_pkg::ACQ_TIME_LSB +: 2];
  assign type_code = ctrl_reg[acc_pkg::CONV_TYPE_LSB +: 3];
  assign do_write = aw_have_reg && w_have_reg && !o_bvalid;
  assign pwr_ready = (pwr_cnt_reg == 16'(acc_pkg::POWER_UP_CYCLES));

  // Divider limit: terminal count per clock code; 000 is undivided.
  always_comb begin
    case (clk_code)
      3'h0: div_limit = 5'h00; // R2
      3'h1: div_limit = 5'h01; // R1
      3'h2: div_limit = 5'h03; // R1
      3'h3: div_limit = 5'h07; // R1
      3'h4: div_limit = 5'h0F; // R1
      3'h5: div_limit = 5'h1F; // R1
      default: div_limit = 5'h01; // Unused codes behave as the default.
    endcase
  end

  // Acquisition length in converter clocks, minus one.
  always_comb begin
    case (acq_code)
      2'h0: acq_limit = 5'h01; // R3
      2'h1: acq_limit = 5'h03; // R3
      2'h2: acq_limit = 5'h07; // R3
      default: acq_limit = 5'h0F; // R3
    endcase
  end

  // Trigger selection; starts are only honoured with enable and power.
  always_comb begin
    case (type_code)
      acc_pkg::TYPE_START_PIN: trigger = i_conversion_start_pin; // R9
      acc_pkg::TYPE_TIMER_ONE: trigger = i_general_timer_one; // R9
      acc_pkg::TYPE_TIMER_ZERO: trigger = i_general_timer_zero; // R9
      acc_pkg::TYPE_SW_SINGLE: trigger = 1'b1; // R10
      acc_pkg::TYPE_SW_CONT: trigger = 1'b1; // R11
      acc_pkg::TYPE_LOGIC_ARRAY: trigger = i_logic_array_trigger; // R12
      default: trigger = 1'b0; // Unused codes never start.
    endcase
  end

  // Base clock divider producing one-cycle converter ticks.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_cnt_reg <= 5'h00;
      conv_tick <= 1'b0;
    end else if (div_cnt_reg >= div_limit) begin
      div_cnt_reg <= 5'h00; // R1
      conv_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
      conv_tick <= 1'b0;
    end
  end

  // Power settle counter restarts whenever power is off.
  always_ff @(posedge i_clock) begin
    if (i_rst || !ctrl_reg[acc_pkg::POWER_BIT]) begin
      pwr_cnt_reg <= 16'h0000; // R6
    end else if (!pwr_ready) begin
      pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
    end
  end

  // Conversion sequencer: acquire, then a fixed number of trial clocks.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= acc_pkg::ACC_IDLE;
      phase_cnt_reg <= 5'h00;
      single_done <= 1'b0;
    end else begin
      single_done <= 1'b0;
      case (state_reg)
        acc_pkg::ACC_IDLE: begin
          // Disabled start blocks new conversions.
          // A finished single start waits for its type rewrite to land.
          if (conv_tick && trigger && ctrl_reg[acc_pkg::START_EN_BIT] &&
              ctrl_reg[acc_pkg::POWER_BIT] && !single_done) begin // R4 R10
            state_reg <= acc_pkg::ACC_ACQUIRE;
            phase_cnt_reg <= 5'h00;
          end
        end
        acc_pkg::ACC_ACQUIRE: begin
          if (conv_tick) begin
            if (phase_cnt_reg == acq_limit) begin // R3
              state_reg <= acc_pkg::ACC_CONVERT;
              phase_cnt_reg <= 5'h00;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 5'h01;
            end
          end
        end
        acc_pkg::ACC_CONVERT: begin
          if (conv_tick) begin
            if (phase_cnt_reg == acc_pkg::CONV_EXTRA_CLOCKS - 5'h01) begin
              single_done <= (type_code == acc_pkg::TYPE_SW_SINGLE);
              // Continuous mode restarts regardless of start enable.
              if (type_code == acc_pkg::TYPE_SW_CONT &&
                  ctrl_reg[acc_pkg::POWER_BIT]) begin // R11
                state_reg <= acc_pkg::ACC_ACQUIRE; // R4
              end else begin
                state_reg <= acc_pkg::ACC_IDLE;
              end
              phase_cnt_reg <= 5'h00;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 5'h01;
            end
          end
        end
        default: state_reg <= acc_pkg::ACC_IDLE;
      endcase
      // Power-down abandons any conversion that is still in flight.
      if (!ctrl_reg[acc_pkg::POWER_BIT]) begin // R6
        state_reg <= acc_pkg::ACC_IDLE;
        phase_cnt_reg <= 5'h00;
      end
    end
  end

  // Analog-side outputs, all registered.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_converter_base_tick <= 1'b0;
      o_sample <= 1'b0;
      o_result_strobe <= 1'b0;
      o_converter_busy_pin <= 1'b0;
      o_converter_power <= 1'b0;
      o_conv_mode <= 2'h0;
    end else begin
      o_converter_base_tick <= conv_tick;
      // Sampling is never shown to a core that is being powered down.
      o_sample <= (state_reg == acc_pkg::ACC_ACQUIRE) &&
        ctrl_reg[acc_pkg::POWER_BIT]; // R6
      o_result_strobe <= conv_tick && (state_reg == acc_pkg::ACC_CONVERT)
        && (phase_cnt_reg == acc_pkg::CONV_EXTRA_CLOCKS - 5'h01);
      // Busy covers acquisition and trials, only when enabled.
      o_converter_busy_pin <= ctrl_reg[acc_pkg::BUSY_EN_BIT] &&
        (state_reg != acc_pkg::ACC_IDLE); // R5 R14
      o_converter_power <= ctrl_reg[acc_pkg::POWER_BIT]; // R6
      // Mode 00/01/10 pass to the core; 11 is reserved, held as 00.
      if (ctrl_reg[acc_pkg::CONV_MODE_LSB +: 2] == 2'h3) begin // R7
        o_conv_mode <= 2'h0;
      end else begin
        o_conv_mode <= ctrl_reg[acc_pkg::CONV_MODE_LSB +: 2]; // R7 R8
      end
    end
  end

  // Control register: software write, and single-type self rewrite.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_reg <= acc_pkg::CONV_CTRL_RESET;
    end else begin
      if (do_write && aw_addr_reg == acc_pkg::CONV_CTRL_OFFSET) begin
        if (w_strb_reg[0]) begin
          ctrl_reg[7:0] <= w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
          ctrl_reg[15:8] <= w_data_reg[15:8] & acc_pkg::CONV_CTRL_MASK[15:8];
        end
      end
      // Hardware rewrite wins over a same-cycle software write.
      if (single_done) begin
        ctrl_reg[acc_pkg::CONV_TYPE_LSB +: 3] <= acc_pkg::TYPE_START_PIN; // R10
      end
    end
  end

  // Write address and data are each latched on their own handshake.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else begin
      o_awready <= !aw_have_reg && !(o_awready && i_awvalid);
      o_wready <= !w_have_reg && !(o_wready && i_wvalid);
      if (o_awready && i_awvalid) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_have_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      // Response once both halves are in; unmapped gives SLVERR.
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr_reg == acc_pkg::CONV_CTRL_OFFSET) ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // Read channel: control register, status register, else SLVERR.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= 2'h0;
    end else begin
      o_arready <= !o_rvalid && !(o_arready && i_arvalid);
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        if (i_araddr == acc_pkg::CONV_CTRL_OFFSET) begin
          o_rdata <= {16'h0000, ctrl_reg};
          o_rresp <= 2'h0;
        end else if (i_araddr == acc_pkg::CONV_STAT_OFFSET) begin
          o_rdata <= {29'h00000000, pwr_ready,
            state_reg == acc_pkg::ACC_CONVERT,
            state_reg != acc_pkg::ACC_IDLE};
          o_rresp <= 2'h0;
        end else begin
          o_rdata <= 32'h00000000;
          o_rresp <= 2'h2;
        end
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule // acc_conversion_control

// file: shared/acc_pkg.sv
// Package of constants and types for the converter control block.
package acc_pkg;
  // Register byte offset of the converter control register.
  localparam logic [7:0] CONV_CTRL_OFFSET = 8'h00;
  // Register byte offset of the status register.
  localparam logic [7:0] CONV_STAT_OFFSET = 8'h04;
  // Reset value of the control register.
  localparam logic [15:0] CONV_CTRL_RESET = 16'h0600;
  // Field positions inside the control register.
  localparam int CLK_SPEED_LSB = 10;
  localparam int ACQ_TIME_LSB = 8;
  localparam int START_EN_BIT = 7;
  localparam int BUSY_EN_BIT = 6;
  localparam int POWER_BIT = 5;
  localparam int CONV_MODE_LSB = 3;
  localparam int CONV_TYPE_LSB = 0;
  // Mask of writable control bits; bits 15:13 are reserved.
  localparam logic [15:0] CONV_CTRL_MASK = 16'h1FFF;
  // Conversion type codes.
  localparam logic [2:0] TYPE_START_PIN = 3'h0;
  localparam logic [2:0] TYPE_TIMER_ONE = 3'h1;
  localparam logic [2:0] TYPE_TIMER_ZERO = 3'h2;
  localparam logic [2:0] TYPE_SW_SINGLE = 3'h3;
  localparam logic [2:0] TYPE_SW_CONT = 3'h4;
  localparam logic [2:0] TYPE_LOGIC_ARRAY = 3'h5;
  // Number of converter clocks spent after acquisition (bit trials).
  localparam logic [4:0] CONV_EXTRA_CLOCKS = 5'h13;
  // Power-up settling time in nanoseconds and in system clocks.
  localparam int POWER_UP_NS = 5000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int POWER_UP_CYCLES = (POWER_UP_NS + CLOCK_PERIOD_NS - 1)
    / CLOCK_PERIOD_NS;
  // Sequencer states.
  typedef enum logic [1:0] {ACC_IDLE, ACC_ACQUIRE, ACC_CONVERT} acc_state_t;
endpackage

// file: testbench/acc_conversion_control_assertions.sv
// Port checks for the converter control block.
`timescale 1ns/1ns
module acc_conversion_control_checker (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst,
  // Register bus handshakes.
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  // Converter side.
  input wire logic o_converter_power,
  input wire logic [1:0] o_conv_mode,
  input wire logic o_converter_base_tick,
  input wire logic o_sample,
  input wire logic o_result_strobe,
  input wire logic o_converter_busy_pin
);
  // All checks share one clock and its reset.
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  property p_sample_power;
    o_sample |-> o_converter_power;
  endproperty
  a_sample_power: assert property (p_sample_power)
    else $error("sampling while powered down");
  property p_mode_legal;
    o_conv_mode != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("reserved input mode driven");
  property p_busy_start;
    $rose(o_converter_busy_pin) |-> o_sample;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose outside acquisition");
  property p_sample_tick;
    $rose(o_sample) |-> $past(o_converter_base_tick);
  endproperty
  a_sample_tick: assert property (p_sample_tick)
    else $error("acquisition began off a converter tick");
  property p_strobe_pulse;
    o_result_strobe |=> !o_result_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("result strobe longer than one cycle");
  property p_bvalid_hold;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped early");
  property p_rvalid_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped or changed early");
  property p_write_answer;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  property p_read_answer;
    i_arvalid && o_arready |-> ##[1:2] o_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read response late");
endmodule // acc_conversion_control_checker
bind acc_conversion_control acc_conversion_control_checker acc_checker_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_rdata(o_rdata), .o_converter_power(o_converter_power),
  .o_conv_mode(o_conv_mode), .o_converter_base_tick(o_converter_base_tick),
  .o_sample(o_sample), .o_result_strobe(o_result_strobe),
  .o_converter_busy_pin(o_converter_busy_pin));

// file: testbench/acc_trigger_model.sv
// Trigger source model that holds one chosen trigger line high.
`timescale 1ns/1ns
module acc_trigger_model #(
  parameter int HOLD = 4
) (
  // Clock.
  input wire logic i_clock,
  // Request to raise the line chosen by i_which.
  input wire logic i_go,
  input wire logic [1:0] i_which,
  // Lines: start pin, timer one, timer zero, logic array.
  output logic [3:0] o_trig
);
  int cnt = 0;
  logic [1:0] sel = 2'h0;
  // Counts the hold time down after each request.
  always @(posedge i_clock) begin
    if (i_go) begin
      cnt <= HOLD;
      sel <= i_which;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Lines rest low between requests, so no stale level lingers.
  assign o_trig = (cnt > 0) ? (4'h1 << sel) : 4'h0;
endmodule // acc_trigger_model

// file: testbench/tb_adc_conversion_control.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module tb_adc_conversion_control;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d, r;
    logic [1:0] e, m;
  } acc_row_t;
  acc_row_t rows [6] = '{
    '{8'h00, 32'h00000620, 32'h00000620, 2'h0, 2'h0},
    '{8'h00, 32'h00000628, 32'h00000628, 2'h0, 2'h1},
    '{8'h00, 32'h00000630, 32'h00000630, 2'h0, 2'h2},
    '{8'h00, 32'h00000638, 32'h00000638, 2'h0, 2'h0},
    '{8'h08, 32'h00000628, 32'h00000000, 2'h2, 2'h0},
    '{8'h00, 32'hFFFFFFFF, 32'h00001FFF, 2'h0, 2'h0}};
  logic [2:0] ck [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [1:0] aq [6] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h1};
  logic [2:0] tt [4] = '{acc_pkg::TYPE_START_PIN, acc_pkg::TYPE_TIMER_ONE,
    acc_pkg::TYPE_TIMER_ZERO, acc_pkg::TYPE_LOGIC_ARRAY};
  logic i_clock = 1'b0, i_rst = 1'b1, go = 1'b0, s_q = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdat, rd, cfg;
  logic [1:0] which = 2'h0, resp, bresp, rresp, mode;
  logic [3:0] trig;
  logic awready, wready, bvalid, arready, rvalid;
  logic tick, sample, strobe, power, busy;
  int failures = 0, n_compared = 0, starts = 0, strobes = 0, busy_hi = 0;
  int w, k, s0, div;
  acc_conversion_control acc_conversion_control_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rd), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_conversion_start_pin(trig[0]), .i_general_timer_one(trig[1]),
    .i_general_timer_zero(trig[2]), .i_logic_array_trigger(trig[3]),
    .o_converter_power(power), .o_conv_mode(mode),
    .o_converter_base_tick(tick), .o_sample(sample),
    .o_result_strobe(strobe), .o_converter_busy_pin(busy));
  acc_trigger_model acc_trigger_model_i (.i_clock(i_clock), .i_go(go),
    .i_which(which), .o_trig(trig));
  // Clock at 100 MHz.
  always #5 i_clock = ~i_clock;
  // Counts acquisitions, results and busy cycles.
  always @(posedge i_clock) begin
    s_q <= sample;
    if (sample && !s_q) starts++;
    if (strobe) strobes++;
    if (busy) busy_hi++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One register write; bready stands from the request to the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    resp = 2'bxx;
    forever begin
      @(posedge i_clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask
  // One register read.
  task automatic rdr(input logic [7:0] a);
    @(posedge i_clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    resp = 2'bxx;
    forever begin
      @(posedge i_clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        resp = rresp;
        rdat = rd;
        break;
      end
    end
    rready <= 1'b0;
  endtask
  task automatic pulse(input logic [1:0] l);
    @(posedge i_clock);
    which <= l;
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
  endtask
  // Measures acquisition width and start-to-result span in cycles.
  task automatic conv();
    w = 0;
    k = 0;
    repeat (3000) begin
      @(posedge i_clock);
      if (sample) break;
    end
    chk(32'(busy), 32'h00000001);
    while (!strobe && k < 3000) begin
      if (sample) w++;
      k++;
      @(posedge i_clock);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    rdr(8'h00);
    chk(rdat, 32'h00000600);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(32'(resp), 32'(rows[i].e));
      rdr(rows[i].a);
      chk(32'(resp), 32'(rows[i].e));
      if (rows[i].e == 2'h0) chk(rdat, rows[i].r);
      chk(32'(mode), 32'(rows[i].m));
      chk(32'(power), 32'h00000001);
    end
    repeat (500) @(posedge i_clock);
    rdr(8'h04);
    chk(rdat, 32'h00000004);
    foreach (ck[i]) begin
      cfg = {19'h0, ck[i], aq[i], 8'hE3};
      div = (ck[i] == 3'h0) ? 1 : (1 << ck[i]);
      wr(8'h00, cfg);
      conv();
      chk(32'(w), 32'((2 << aq[i]) * div));
      // Sample shows a cycle after the start tick, the strobe at the last.
      chk(32'(k), 32'(((2 << aq[i]) + 19) * div - 1));
      rdr(8'h00);
      chk(rdat, cfg & 32'hFFFFFFF8);
      wr(8'h00, cfg & 32'h00001F78);
    end
    s0 = busy_hi;
    foreach (tt[i]) begin
      wr(8'h00, {24'h0, 5'h14, tt[i]});
      k = starts;
      pulse(2'(i + 1));
      repeat (40) @(posedge i_clock);
      chk(32'(starts), 32'(k));
      pulse(2'(i));
      repeat (40) @(posedge i_clock);
      chk(32'(starts), 32'(k + 1));
    end
    chk(32'(busy_hi), 32'(s0));
    wr(8'h00, 32'h00000020);
    pulse(2'h0);
    repeat (40) @(posedge i_clock);
    chk(32'(starts), 32'(k + 1));
    k = strobes;
    wr(8'h00, 32'h000000A4);
    repeat (100) @(posedge i_clock);
    chk(32'(strobes - k >= 3), 32'h00000001);
    k = strobes;
    wr(8'h00, 32'h00000024);
    repeat (100) @(posedge i_clock);
    chk(32'(strobes - k >= 3), 32'h00000001);
    wr(8'h00, 32'h00000020);
    repeat (30) @(posedge i_clock);
    k = strobes;
    repeat (100) @(posedge i_clock);
    chk(32'(strobes), 32'(k));
    wr(8'h00, 32'h00000000);
    repeat (2) @(posedge i_clock);
    chk(32'(power), 32'h00000000);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    rdr(8'h00);
    chk(rdat, 32'h00000600);
    print_verdict();
  end
endmodule // tb_adc_conversion_control
